// [logic/pwr_pkg.sv]
// shared constants, types and helpers for the power-down clock control pair
package pwr_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int NUM_MOD = 9;
   localparam int DIV_W = 3;
   // device register offsets
   localparam logic [7:0] STBY_OFS = 8'h00;
   localparam logic [7:0] FRQ_OFS = 8'h04;
   localparam logic [7:0] DSTAT_OFS = 8'h08;
   // standby_control_reg fields
   localparam int STOP_BASIC_SER = 0;
   localparam int STOP_RTC = 1;
   localparam int STOP_TIMER = 2;
   localparam int STOP_IR_SER = 3;
   localparam int STOP_FIFO_SER = 4;
   localparam int STOP_ADC = 5;
   localparam int STOP_DAC = 6;
   localparam int STOP_DMA = 7;
   localparam int STOP_BRK = 8;
   localparam int SLP_STOP_BIT = 9;
   localparam int STBY_SEL_BIT = 10;
   localparam logic [15:0] STBY_WMASK = 16'h07ff;
   localparam logic [15:0] STBY_RESET = 16'h0000;
   // frequency_control_reg fields
   localparam int FRQ_MULT_LSB = 0;
   localparam int FRQ_IDIV_LSB = 4;
   localparam int FRQ_PDIV_LSB = 8;
   localparam int FRQ_PSRC_BIT = 12;
   localparam logic [15:0] FRQ_WMASK = 16'h1777;
   localparam logic [15:0] FRQ_RESET = 16'h0300;
   // device status bits
   localparam int DST_HW_BIT = 0;
   localparam int DST_SW_BIT = 1;
   localparam int DST_SLEEP_BIT = 2;
   localparam int DST_PEND_BIT = 3;
   localparam int DST_TOUCH_BIT = 4;
   // clock mode pin codes
   localparam logic [2:0] MODE_EXT_X1 = 3'h0;
   localparam logic [2:0] MODE_EXT_X4 = 3'h1;
   localparam logic [2:0] MODE_CRYSTAL_OUTPUT_X4 = 3'h2;
   localparam logic [2:0] MODE_BUS_IN = 3'h7;
   // controller register offsets and fields
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] HSTAT_OFS = 8'h04;
   localparam logic [7:0] DADDR_OFS = 8'h08;
   localparam logic [7:0] DWDATA_OFS = 8'h0c;
   localparam logic [7:0] DCMD_OFS = 8'h10;
   localparam logic [7:0] DRDATA_OFS = 8'h14;
   localparam int CTRL_STBY_BIT = 0;
   localparam int CMD_WR_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   localparam int HS_BUSY_BIT = 0;
   localparam int HS_DEV_HW_BIT = 1;
   localparam int HS_OSC_BIT = 2;
   localparam int HS_POR_BIT = 3;
   // oscillator settling held under power-on reset
   localparam int CLK_PERIOD_NS = 40;
   localparam int OSC_SETTLE_NS = 10000;
   localparam int OSC_SETTLE_CYC =
      (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = $clog2(OSC_SETTLE_CYC + 1);

   typedef enum logic [2:0] {
      ST_RUN, ST_SLEEP, ST_SW_STANDBY, ST_SETTLE, ST_HW_STANDBY
   } pwr_state_t;
   typedef enum logic [1:0] {
      CS_IDLE, CS_TOUCH, CS_ACCESS, CS_READ
   } ctl_state_t;
   typedef enum logic [1:0] {SQ_ACTIVE, SQ_STANDBY, SQ_POR_LOW, SQ_WAKE} seq_t;

   // ratio select code to divide or multiply factor 1,2,3,4,6
   function automatic logic [DIV_W-1:0] ratio_of(input logic [DIV_W-1:0] sel);
      case (sel)
         3'h1: ratio_of = 3'h2;
         3'h2: ratio_of = 3'h3;
         3'h3: ratio_of = 3'h4;
         3'h4: ratio_of = 3'h6;
         default: ratio_of = 3'h1;
      endcase
   endfunction : ratio_of
endpackage : pwr_pkg

// [logic/pwr_link_if.sv]
// link between the clock/power device and its external controller
`timescale 1ns/10ps
interface pwr_link_if;
   import pwr_pkg::*;
   logic standby_req_n;
   logic poweron_reset_n;
   logic manual_reset;
   logic irq;
   logic rtc_tick;
   logic periph_touch;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic osc_run;
   logic hw_standby;

   modport dev (
      input standby_req_n, poweron_reset_n, manual_reset, irq, rtc_tick,
      input periph_touch, reg_addr, reg_wdata, reg_wr, reg_rd,
      output reg_rdata, osc_run, hw_standby
   );
   modport ctl (
      output standby_req_n, poweron_reset_n, manual_reset, irq, rtc_tick,
      output periph_touch, reg_addr, reg_wdata, reg_wr, reg_rd,
      input reg_rdata, osc_run, hw_standby
   );
endinterface : pwr_link_if

// [logic/pwr_device_end.sv]
// power-down sequencing, module clock gating and clock dividers
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - stop bit set halts that module clock
// - bits 8..0 map break..basic serial
// - adc gating resets all adc registers
// - timer gating clears timer start register
// - rtc counter runs; no access while gated
// - touch rtc/serial/timer before gating rtc
// - timer pins hold, serial pins reset
// - clear bits or reset ends module standby
// - standby pin low enters hardware standby
// - hw standby ignores irq, reset; timer pin low
// - from software standby go straight in
// - from sleep or settle, resume first
// - only power-on reset leaves hardware standby
// - pin high under reset restarts oscillator
// - two consecutive low rtc samples accept request
// - controller holds pin low throughout
// - no irq or manual reset meanwhile
// - pll1 multiplies 1,2,3,4,6, edges aligned
// - mode pins fix pll2 ratio x1 or x4
// - internal divider never slower than bus
// - peripheral divider never faster than bus
module pwr_device_end (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_ce,
   pwr_link_if.dev link,
   input wire logic [2:0] i_mode_pins,
   input wire logic i_sleep_req,
   input wire logic i_settle_done,
   output logic o_bus_clk_en,
   output logic o_cpu_clk_en,
   output logic o_per_clk_en,
   output logic [pwr_pkg::NUM_MOD-1:0] o_mod_clk_en,
   output logic o_rtc_count_en,
   output logic o_adc_init,
   output logic o_timer_start_clr,
   output logic o_timer_pins_hold,
   output logic [2:0] o_serial_pins_reset,
   output logic o_timer_clock_pin,
   output logic o_pll2_on,
   output logic o_pll2_x4,
   output logic o_mode_reserved
);
   import pwr_pkg::*;

   pwr_state_t state_reg, state_next;
   logic [DATA_W-1:0] stby_reg, frq_reg, rdata_reg;
   logic ca_low_reg, hw_pend_reg, touch_reg;
   logic [DIV_W-1:0] pll_cnt_reg, int_cnt_reg, per_cnt_reg;
   logic [NUM_MOD-1:0] mod_en_next;

   wire in_hw = (state_reg == ST_HW_STANDBY);
   wire in_sw = (state_reg == ST_SW_STANDBY);
   wire por_act = ~link.poweron_reset_n;
   wire man_rst = link.manual_reset & ~in_hw;
   wire soft_rst = por_act | man_rst;
   // a low sample must follow a low sample on the rtc tick
   wire ca_accept = link.rtc_tick & ~link.standby_req_n & ca_low_reg;
   wire wr_stby = link.reg_wr & (link.reg_addr == STBY_OFS);
   wire wr_frq = link.reg_wr & (link.reg_addr == FRQ_OFS);
   wire [NUM_MOD-1:0] stop = stby_reg[NUM_MOD-1:0];
   wire running = (state_reg == ST_RUN) | (state_reg == ST_SLEEP);

   wire [DIV_W-1:0] mult = ratio_of(frq_reg[FRQ_MULT_LSB +: DIV_W]);
   wire [DIV_W-1:0] idiv_raw = ratio_of(frq_reg[FRQ_IDIV_LSB +: DIV_W]);
   wire [DIV_W-1:0] pdiv_raw = ratio_of(frq_reg[FRQ_PDIV_LSB +: DIV_W]);
   wire per_src_bus = frq_reg[FRQ_PSRC_BIT];
   // illegal ratios are clamped rather than refused
   wire [DIV_W-1:0] idiv = (idiv_raw > mult) ? mult : idiv_raw;
   wire [DIV_W-1:0] pdiv =
      (!per_src_bus && pdiv_raw < mult) ? mult : pdiv_raw;

   wire pll_wrap = (pll_cnt_reg >= mult - 3'h1);
   wire bus_tick = running & (pll_cnt_reg == 3'h0);
   wire int_tick = running & (int_cnt_reg == 3'h0);
   wire per_step = per_src_bus ? bus_tick : running;
   wire per_tick = per_step & (per_cnt_reg == 3'h0);
   wire [DIV_W-1:0] pll_cnt_next = pll_wrap ? 3'h0 : pll_cnt_reg + 3'h1;
   // internal divider restarts with each bus edge for alignment
   wire [DIV_W-1:0] int_cnt_next =
      (pll_wrap || int_cnt_reg >= idiv - 3'h1) ? 3'h0 : int_cnt_reg + 3'h1;
   wire [DIV_W-1:0] per_cnt_next = !per_step ? per_cnt_reg :
      (per_cnt_reg >= pdiv - 3'h1) ? 3'h0 : per_cnt_reg + 3'h1;

   wire [DATA_W-1:0] dstat = DATA_W'({touch_reg, hw_pend_reg,
      state_reg == ST_SLEEP, in_sw, in_hw});
   wire [DATA_W-1:0] rd_mux =
      (link.reg_addr == STBY_OFS) ? stby_reg :
      (link.reg_addr == FRQ_OFS) ? frq_reg :
      (link.reg_addr == DSTAT_OFS) ? dstat : '0;
   wire timer_gate_set = wr_stby & link.reg_wdata[STOP_TIMER] &
      ~stop[STOP_TIMER];
   wire sw_entry = (state_next == ST_SW_STANDBY) & ~in_sw;

   // every module gate is a registered enable, so no runt clock can occur
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++) begin : g_gate
         if (gi == STOP_RTC) begin : g_rtc
            // rtc-clocked logic keeps running through sleep, software and hardware standby; only its stop bit halts it
            assign mod_en_next[gi] = link.rtc_tick & ~stop[gi];
         end else begin : g_per
            assign mod_en_next[gi] = per_tick & ~stop[gi];
         end
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (hw_pend_reg | ca_accept)
               state_next = ST_HW_STANDBY;
            else if (i_sleep_req)
               state_next = stby_reg[STBY_SEL_BIT] ? ST_SW_STANDBY : ST_SLEEP;
         end
         ST_SLEEP: begin
            if (link.irq)
               state_next = ST_RUN;
         end
         ST_SW_STANDBY: begin
            if (hw_pend_reg | ca_accept)
               state_next = ST_HW_STANDBY;
            else if (link.irq)
               state_next = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (i_settle_done)
               state_next = ST_RUN;
         end
         ST_HW_STANDBY: state_next = ST_HW_STANDBY;
         default: state_next = ST_RUN;
      endcase
      // oscillator restarts only once the pin rises under reset
      if (por_act)
         state_next = (in_hw & ~link.standby_req_n) ?
            ST_HW_STANDBY : ST_RUN;
      else if (man_rst)
         state_next = ST_RUN;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ST_RUN;
         ca_low_reg <= 1'b0;
         hw_pend_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         if (link.rtc_tick)
            ca_low_reg <= ~link.standby_req_n;
         // a request seen in sleep or settle waits for the cpu to resume
         if (soft_rst)
            hw_pend_reg <= 1'b0;
         else if (ca_accept)
            hw_pend_reg <= 1'b1;
         else if (state_next == ST_HW_STANDBY)
            hw_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stby_reg <= STBY_RESET;
         frq_reg <= FRQ_RESET;
         touch_reg <= 1'b0;
      end else if (i_ce) begin
         if (soft_rst) begin
            stby_reg <= STBY_RESET;
            frq_reg <= FRQ_RESET;
         end else if (wr_stby) begin
            stby_reg <= link.reg_wdata & STBY_WMASK;
         end else if (wr_frq) begin
            frq_reg <= link.reg_wdata & FRQ_WMASK;
         end
         // records the access that must precede rtc gating
         if (soft_rst)
            touch_reg <= 1'b0;
         else if (link.periph_touch)
            touch_reg <= 1'b1;
         else if (wr_stby)
            touch_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pll_cnt_reg <= 3'h0;
         int_cnt_reg <= 3'h0;
         per_cnt_reg <= 3'h0;
      end else if (i_ce) begin
         // halted clocks restart from a common edge
         pll_cnt_reg <= running ? pll_cnt_next : 3'h0;
         int_cnt_reg <= running ? int_cnt_next : 3'h0;
         per_cnt_reg <= running ? per_cnt_next : 3'h0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_bus_clk_en <= 1'b0;
         o_cpu_clk_en <= 1'b0;
         o_per_clk_en <= 1'b0;
         o_mod_clk_en <= '0;
         o_rtc_count_en <= 1'b0;
         o_timer_start_clr <= 1'b0;
         o_timer_clock_pin <= 1'b0;
      end else if (i_ce) begin
         o_bus_clk_en <= bus_tick;
         o_cpu_clk_en <= int_tick & (state_reg == ST_RUN);
         o_per_clk_en <= per_tick;
         o_mod_clk_en <= mod_en_next;
         o_rtc_count_en <= link.rtc_tick;
         o_timer_start_clr <= timer_gate_set | sw_entry;
         if (in_hw | por_act)
            o_timer_clock_pin <= 1'b0;
         else if (mod_en_next[STOP_TIMER])
            o_timer_clock_pin <= ~o_timer_clock_pin;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_adc_init <= 1'b0;
         o_timer_pins_hold <= 1'b0;
         o_serial_pins_reset <= 3'h0;
         o_pll2_on <= 1'b1;
         o_pll2_x4 <= 1'b0;
         o_mode_reserved <= 1'b0;
      end else if (i_ce) begin
         o_adc_init <= stop[STOP_ADC];
         o_timer_pins_hold <= stop[STOP_TIMER];
         o_serial_pins_reset <= {stop[STOP_FIFO_SER], stop[STOP_IR_SER],
            stop[STOP_BASIC_SER]};
         o_pll2_on <= (i_mode_pins != MODE_BUS_IN);
         o_pll2_x4 <= (i_mode_pins == MODE_EXT_X4) |
            (i_mode_pins == MODE_CRYSTAL_OUTPUT_X4);
         o_mode_reserved <= (i_mode_pins != MODE_EXT_X1) &
            (i_mode_pins != MODE_EXT_X4) & (i_mode_pins != MODE_CRYSTAL_OUTPUT_X4) &
            (i_mode_pins != MODE_BUS_IN);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_reg <= '0;
         link.osc_run <= 1'b1;
         link.hw_standby <= 1'b0;
      end else if (i_ce) begin
         rdata_reg <= link.reg_rd ? rd_mux : '0;
         link.osc_run <= ~((state_next == ST_SW_STANDBY) |
            (state_next == ST_HW_STANDBY));
         link.hw_standby <= (state_next == ST_HW_STANDBY);
      end
   end
   assign link.reg_rdata = rdata_reg;
endmodule : pwr_device_end

// [logic/pwr_controller_end.sv]
// external controller: standby pin, power-on reset and register bridge
`timescale 1ns/10ps
module pwr_controller_end (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_ce,
   pwr_link_if.ctl link,
   input wire logic [pwr_pkg::ADDR_W-1:0] i_addr,
   input wire logic [pwr_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [pwr_pkg::DATA_W-1:0] o_rdata,
   input wire logic i_irq_src,
   input wire logic i_manual_reset_req,
   input wire logic i_rtc_tick
);
   import pwr_pkg::*;

   ctl_state_t cst_reg, cst_next;
   seq_t seq_reg, seq_next;
   logic ctrl_stby_reg, cmd_rd_reg;
   logic [ADDR_W-1:0] daddr_reg;
   logic [DATA_W-1:0] dwdata_reg, drdata_reg;
   logic [SETTLE_W-1:0] settle_cnt_reg;

   wire idle = (cst_reg == CS_IDLE);
   wire active = (seq_reg == SQ_ACTIVE);
   wire launch = i_wr & (i_addr == DCMD_OFS) & idle &
      (i_wdata[CMD_WR_BIT] | i_wdata[CMD_RD_BIT]);
   wire launch_rd = i_wdata[CMD_RD_BIT];
   // a write that gates the rtc is preceded by a peripheral access
   wire need_touch = ~launch_rd & (daddr_reg == STBY_OFS) &
      dwdata_reg[STOP_RTC];
   wire settle_done =
      (settle_cnt_reg == SETTLE_W'(OSC_SETTLE_CYC - 1));
   wire [DATA_W-1:0] hstat = DATA_W'({~link.poweron_reset_n, link.osc_run,
      link.hw_standby, ~idle});
   wire [DATA_W-1:0] rd_mux =
      (i_addr == CTRL_OFS) ? DATA_W'(ctrl_stby_reg) :
      (i_addr == HSTAT_OFS) ? hstat :
      (i_addr == DADDR_OFS) ? DATA_W'(daddr_reg) :
      (i_addr == DWDATA_OFS) ? dwdata_reg :
      (i_addr == DRDATA_OFS) ? drdata_reg : '0;

   always_comb begin
      cst_next = cst_reg;
      case (cst_reg)
         CS_IDLE: begin
            if (launch)
               cst_next = need_touch ? CS_TOUCH : CS_ACCESS;
         end
         CS_TOUCH: cst_next = CS_ACCESS;
         CS_ACCESS: cst_next = cmd_rd_reg ? CS_READ : CS_IDLE;
         CS_READ: cst_next = CS_IDLE;
         default: cst_next = CS_IDLE;
      endcase
   end

   always_comb begin
      seq_next = seq_reg;
      case (seq_reg)
         SQ_ACTIVE: begin
            if (ctrl_stby_reg)
               seq_next = SQ_STANDBY;
         end
         SQ_STANDBY: begin
            if (!ctrl_stby_reg)
               seq_next = SQ_POR_LOW;
         end
         SQ_POR_LOW: seq_next = SQ_WAKE;
         SQ_WAKE: begin
            if (settle_done)
               seq_next = SQ_ACTIVE;
         end
         default: seq_next = SQ_ACTIVE;
      endcase
   end

   // pin held low until reset is already low, then released
   assign link.standby_req_n = ~((seq_reg == SQ_STANDBY) |
      (seq_reg == SQ_POR_LOW));
   assign link.poweron_reset_n = ~((seq_reg == SQ_POR_LOW) |
      (seq_reg == SQ_WAKE));
   assign link.irq = i_irq_src & ~link.hw_standby;
   assign link.manual_reset = i_manual_reset_req & active;
   assign link.rtc_tick = i_rtc_tick;
   assign link.periph_touch = (cst_reg == CS_TOUCH);
   assign link.reg_wr = (cst_reg == CS_ACCESS) & ~cmd_rd_reg;
   assign link.reg_rd = (cst_reg == CS_ACCESS) & cmd_rd_reg;
   assign link.reg_addr = daddr_reg;
   assign link.reg_wdata = dwdata_reg;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cst_reg <= CS_IDLE;
         seq_reg <= SQ_ACTIVE;
         settle_cnt_reg <= '0;
      end else if (i_ce) begin
         cst_reg <= cst_next;
         seq_reg <= seq_next;
         settle_cnt_reg <= (seq_reg == SQ_WAKE) ?
            settle_cnt_reg + SETTLE_W'(1) : '0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_stby_reg <= 1'b0;
         cmd_rd_reg <= 1'b0;
         daddr_reg <= '0;
         dwdata_reg <= '0;
         drdata_reg <= '0;
         o_rdata <= '0;
      end else if (i_ce) begin
         if (i_wr && i_addr == CTRL_OFS)
            ctrl_stby_reg <= i_wdata[CTRL_STBY_BIT];
         // bridge fields are frozen while an access is under way
         if (i_wr && idle && i_addr == DADDR_OFS)
            daddr_reg <= i_wdata[ADDR_W-1:0];
         if (i_wr && idle && i_addr == DWDATA_OFS)
            dwdata_reg <= i_wdata;
         if (launch)
            cmd_rd_reg <= launch_rd;
         if (cst_reg == CS_READ)
            drdata_reg <= link.reg_rdata;
         o_rdata <= i_rd ? rd_mux : '0;
      end
   end
endmodule : pwr_controller_end

// [sim/pwr_link_props.sv]
// concurrent checks on the standby link between the two ends
`timescale 1ns/10ps
module pwr_link_props (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic standby_req_n,
   input wire logic poweron_reset_n,
   input wire logic manual_reset,
   input wire logic irq,
   input wire logic rtc_tick,
   input wire logic periph_touch,
   input wire logic reg_wr,
   input wire logic osc_run,
   input wire logic hw_standby
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   logic [1:0] low_reg;
   logic [1:0] low_next;
   // high sample restarts the count, so one low sample never arms entry
   assign low_next = !rtc_tick ? low_reg : standby_req_n ? 2'h0 :
      (low_reg != 2'h2) ? low_reg + 2'h1 : low_reg;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         low_reg <= 2'h0;
      end else begin
         low_reg <= low_next;
      end
   end
   sequence s_wake;
      hw_standby && standby_req_n && !poweron_reset_n;
   endsequence
   a_two_low_samples: assert property (
      $rose(hw_standby) |-> low_reg == 2'h2)
      else $error("standby entered without two low samples");
   a_osc_off_hw: assert property (
      hw_standby |-> !osc_run)
      else $error("oscillator runs in hw standby");
   a_hw_until_por: assert property (
      hw_standby && !(standby_req_n && !poweron_reset_n) |=> hw_standby)
      else $error("hw standby left without power-on reset");
   a_osc_restart: assert property (
      s_wake |=> osc_run && !hw_standby)
      else $error("oscillator not restarted under reset");
   a_por_held: assert property (
      $fell(poweron_reset_n) |=> !poweron_reset_n [*8])
      else $error("power-on reset released too early");
   a_pin_held_low: assert property (
      hw_standby && poweron_reset_n |-> !standby_req_n)
      else $error("request pin high in hw standby");
   a_hw_quiet: assert property (
      hw_standby |-> !irq && !manual_reset)
      else $error("interrupt or manual reset in hw standby");
   a_touch_first: assert property (
      periph_touch |=> reg_wr)
      else $error("touch not followed by write");
endmodule : pwr_link_props

// [sim/tb_top.sv]
// self-checking bench for the device end and controller end pair
`timescale 1ns/10ps
module tb_top;
   import pwr_pkg::*;
   typedef struct packed {
      logic [15:0] stby;
      logic adc;
      logic tmr;
      logic [2:0] ser;
   } row_t;
   // all clear, then one stop bit at a time, then all, then all cleared again
   row_t rows [12] = '{
      '{16'h0000, 1'b0, 1'b0, 3'h0}, '{16'h0001, 1'b0, 1'b0, 3'h1},
      '{16'h0002, 1'b0, 1'b0, 3'h0}, '{16'h0004, 1'b0, 1'b1, 3'h0},
      '{16'h0008, 1'b0, 1'b0, 3'h2}, '{16'h0010, 1'b0, 1'b0, 3'h4},
      '{16'h0020, 1'b1, 1'b0, 3'h0}, '{16'h0040, 1'b0, 1'b0, 3'h0},
      '{16'h0080, 1'b0, 1'b0, 3'h0}, '{16'h0100, 1'b0, 1'b0, 3'h0},
      '{16'h01ff, 1'b1, 1'b1, 3'h7}, '{16'h0000, 1'b0, 1'b0, 3'h0}
   };
   logic clk_sys = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic irq_src = 1'b0, mrst_req = 1'b0, sleep_req = 1'b0;
   logic rtc_tick = 1'b0, cnt_clr = 1'b1, ptmr = 1'b0;
   logic [2:0] mode = 3'h0, tick_div = 3'h0, ser_rst;
   logic [7:0] addr = 8'h00, tcnt = 8'h00, rcnt, t0;
   logic [7:0] pcnt [9];
   logic [15:0] wdata = 16'h0000, rdata, val;
   logic [8:0] mod_en;
   logic rtc_en, adc_init, tclr, tpins, timer_clock_pin_pin, pll_on, pll_x4, mode_res;
   int n_fail = 0, n_checks = 0;

   pwr_link_if pwr_link_if_i ();
   wire logic hw = pwr_link_if_i.hw_standby;
   wire logic osc = pwr_link_if_i.osc_run;
   pwr_device_end pwr_device_end_i (
      .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(1'b1),
      .link(pwr_link_if_i.dev), .i_mode_pins(mode),
      .i_sleep_req(sleep_req), .i_settle_done(1'b0),
      .o_bus_clk_en(), .o_cpu_clk_en(), .o_per_clk_en(),
      .o_mod_clk_en(mod_en), .o_rtc_count_en(rtc_en),
      .o_adc_init(adc_init), .o_timer_start_clr(tclr),
      .o_timer_pins_hold(tpins), .o_serial_pins_reset(ser_rst),
      .o_timer_clock_pin(timer_clock_pin_pin), .o_pll2_on(pll_on),
      .o_pll2_x4(pll_x4), .o_mode_reserved(mode_res));
   pwr_controller_end pwr_controller_end_i (
      .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(1'b1),
      .link(pwr_link_if_i.ctl), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_src(irq_src),
      .i_manual_reset_req(mrst_req), .i_rtc_tick(rtc_tick));
   pwr_link_props pwr_link_props_i (
      .i_clk_sys(clk_sys), .i_arst_n(arst_n), .hw_standby(hw),
      .standby_req_n(pwr_link_if_i.standby_req_n),
      .poweron_reset_n(pwr_link_if_i.poweron_reset_n),
      .manual_reset(pwr_link_if_i.manual_reset),
      .irq(pwr_link_if_i.irq), .rtc_tick(pwr_link_if_i.rtc_tick),
      .periph_touch(pwr_link_if_i.periph_touch),
      .reg_wr(pwr_link_if_i.reg_wr), .osc_run(osc));

   always #20 clk_sys = ~clk_sys;
   // a tick every eighth cycle stands in for the slow rtc edge
   always @(posedge clk_sys) begin
      tick_div <= tick_div + 3'h1;
      rtc_tick <= tick_div == 3'h7;
   end
   // start-clear pulses are never cleared, so pulses inside a write count
   always @(posedge clk_sys) begin
      tcnt <= tcnt + 8'(tclr === 1'b1);
      rcnt <= cnt_clr ? 8'h00 : rcnt + 8'(rtc_en);
      for (int i = 0; i < 9; i++) begin
         pcnt[i] <= cnt_clr ? 8'h00 : pcnt[i] + 8'(mod_en[i]);
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic sw_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : sw_wr

   task automatic sw_rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 q = rdata;
   endtask : sw_rd

   task automatic dev_acc(input logic [7:0] a, input logic [15:0] d,
         input logic [15:0] cmd, output logic [15:0] q);
      logic [15:0] h;
      h = 16'h0001;
      sw_wr(DADDR_OFS, a);
      sw_wr(DWDATA_OFS, d);
      sw_wr(DCMD_OFS, cmd);
      for (int j = 0; j < 20 && h[HS_BUSY_BIT] !== 1'b0; j++) begin
         sw_rd(HSTAT_OFS, h);
      end
      chk(16'(h[HS_BUSY_BIT]), 16'h0000, "bridge busy");
      sw_rd(DRDATA_OFS, q);
   endtask : dev_acc

   task automatic wait_hw(input logic exp);
      for (int j = 0; j < 100 && hw !== exp; j++) begin
         @(posedge clk_sys);
      end
      #1 chk(16'(hw), 16'(exp), "hw_standby");
   endtask : wait_hw

   task automatic wake;
      sw_wr(CTRL_OFS, 16'h0000);
      repeat (OSC_SETTLE_CYC + 10) @(posedge clk_sys);
      #1 chk(16'(hw), 16'h0000, "hw after wake");
      chk(16'(osc), 16'h0001, "osc after wake");
   endtask : wake

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      dev_acc(STBY_OFS, 16'h0000, 16'h0002, val);
      chk(val, STBY_RESET, "stby after reset");
      sw_rd(8'h40, val);
      chk(val, 16'h0000, "unmapped read");
      $display("reset test done");
      foreach (rows[r]) begin
         cnt_clr <= 1'b1;
         t0 = tcnt;
         dev_acc(STBY_OFS, rows[r].stby, 16'h0001, val);
         cnt_clr <= 1'b0;
         repeat (32) @(posedge clk_sys);
         #1;
         for (int i = 0; i < 9; i++) begin
            chk(16'(pcnt[i] == 8'h00), 16'(rows[r].stby[i]), "gate");
         end
         chk(16'(rcnt == 8'h00), 16'h0000, "rtc count");
         chk(16'(adc_init), 16'(rows[r].adc), "adc init");
         chk(16'(tpins), 16'(rows[r].tmr), "timer pins");
         chk(16'(ser_rst), 16'(rows[r].ser), "serial pins");
         chk(16'(tcnt - t0), 16'(rows[r].tmr & ~ptmr), "start clr");
         ptmr = rows[r].tmr;
         dev_acc(STBY_OFS, 16'h0000, 16'h0002, val);
         chk(val, rows[r].stby, "stby readback");
         $display("row %0d done", r);
      end
      for (int m = 0; m < 8; m++) begin
         @(posedge clk_sys);
         mode <= 3'(m);
         repeat (3) @(posedge clk_sys);
         #1 chk(16'(pll_on), 16'(m != 7), "pll2 on");
         chk(16'(pll_x4), 16'(m == 1 || m == 2), "pll2 x4");
         chk(16'(mode_res), 16'(m > 2 && m < 7), "mode reserved");
      end
      @(posedge clk_sys);
      mode <= 3'h0;
      $display("mode test done");
      dev_acc(STBY_OFS, 16'h0020, 16'h0001, val);
      sw_wr(CTRL_OFS, 16'h0001);
      wait_hw(1'b1);
      chk(16'(osc), 16'h0000, "osc in hw");
      chk(16'(timer_clock_pin_pin), 16'h0000, "timer clock pin");
      @(posedge clk_sys);
      irq_src <= 1'b1;
      mrst_req <= 1'b1;
      repeat (20) @(posedge clk_sys);
      irq_src <= 1'b0;
      mrst_req <= 1'b0;
      #1 chk(16'(hw), 16'h0001, "hw ignores irq");
      wake();
      dev_acc(STBY_OFS, 16'h0000, 16'h0002, val);
      chk(val, STBY_RESET, "stby after por");
      $display("hw standby test done");
      @(posedge clk_sys);
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      sw_wr(CTRL_OFS, 16'h0001);
      repeat (40) @(posedge clk_sys);
      #1 chk(16'(hw), 16'h0000, "no entry in sleep");
      @(posedge clk_sys);
      irq_src <= 1'b1;
      @(posedge clk_sys);
      irq_src <= 1'b0;
      wait_hw(1'b1);
      wake();
      $display("sleep test done");
      dev_acc(STBY_OFS, 16'h0400, 16'h0001, val);
      @(posedge clk_sys);
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 chk(16'(osc), 16'h0000, "osc in sw standby");
      sw_wr(CTRL_OFS, 16'h0001);
      wait_hw(1'b1);
      chk(16'(osc), 16'h0000, "osc stays off");
      wake();
      $display("sw standby test done");
      tally_and_finish();
   end

   // about 1700 cycles expected; over ten times that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      $display("Error watchdog: expected done seen timeout");
      tally_and_finish();
   end
endmodule : tb_top
